// *** hw/emc_accum_unit.sv ***
module emc_accum_unit #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic valid,
   input wire emc_pkg::emc_accum_t mode,
   input wire logic signed [W-1:0] value,
   input wire logic ref_neg,
   input wire logic below_noload,
   output logic signed [W:0] delta,
   output logic delta_valid
);
   if (W < 8)
   begin : g_width_check
      $error("emc_accum_unit: W must be at least 8");
   end

   // One extra bit so that negating the most negative sample cannot overflow.
   wire logic signed [W:0] ext = {value[W-1], value};
   wire logic signed [W:0] neg_ext = -ext;
   logic signed [W:0] pick;

   always_comb
   begin
      case (mode)
         emc_pkg::EMC_ACC_SIGNED: pick = ext;
         emc_pkg::EMC_ACC_ABS: pick = ext[W] ? neg_ext : ext;
         emc_pkg::EMC_ACC_TAMPER: pick = ref_neg ? neg_ext : ext;
         emc_pkg::EMC_ACC_POS: pick = ext[W] ? '0 : ext;
         default: pick = ext;
      endcase
      if (below_noload)
         pick = '0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         delta <= '0;
         delta_valid <= 1'b0;
      end
      else
      begin
         delta_valid <= enable && valid;
         if (enable && valid)
            delta <= pick;
      end
   end
endmodule

// *** hw/emc_ctrl_regs.sv ***
// Overview of operation
// - Bit 7 of the second mode register set stops active power measurement.
// - Reactive sign interrupt: positive-to-negative when select is 0, else reverse.
// - Active sign interrupt: positive-to-negative when select is 0, else reverse.
// - Reactive mode: both clear signed, absolute bit absolute, dependence alone anti-tamper.
// - Anti-tamper adds reactive when active positive, subtracts when active negative.
// - Active mode: both clear signed, absolute bit absolute, positive-only alone positive.
// - Compensation disable clear applies frequency-dependent reactive gain compensation.
// - RMS sync bit set stores RMS values synchronised to line frequency.
// - Apparent no-load: off, or 0.03%, 0.015%, 0.0075% of full scale.
// - Reactive no-load: off, or 0.015%, 0.0075%, 0.0037% of full scale.
// - Active no-load: off, or 0.015%, 0.0075%, 0.0037% of full scale.
// - Active scaling register holds any 8-bit value for the engine.
// - Reactive scaling register holds any 8-bit value for the engine.
// - Apparent scaling register holds any 8-bit value for the engine.
// - Reset clears every register of the bank to zero.
// - The engine runs only while the master enable of the first mode register is set.
`include "emc_defines.svh"

module emc_ctrl_regs #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [`EMC_SFR_AW-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic calc_engine_enable,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] active_power,
   input wire logic signed [W-1:0] reactive_power,
   input wire logic [W-1:0] apparent_power,
   output logic active_meas_en,
   output logic reactive_comp_en,
   output logic rms_line_sync,
   output logic [7:0] active_power_scale,
   output logic [7:0] reactive_power_scale,
   output logic [7:0] apparent_power_scale,
   output logic signed [W:0] active_accum_delta,
   output logic active_accum_valid,
   output logic signed [W:0] reactive_accum_delta,
   output logic reactive_accum_valid,
   output logic apparent_noload,
   output logic reactive_noload,
   output logic active_noload,
   output logic active_sign_change_irq,
   output logic reactive_sign_change_irq
);
   if (W < 16 || W > 32)
   begin : g_width_check
      $error("emc_ctrl_regs: W must lie between 16 and 32");
   end

   // Full scale is the largest magnitude of a signed sample.
   localparam longint FULL_SCALE = longint'(1) << (W - 1);
   localparam logic [W-1:0] APP_T1 = W'(FULL_SCALE * `EMC_NL_APP_T1 / `EMC_NL_DENOM);
   localparam logic [W-1:0] APP_T2 = W'(FULL_SCALE * `EMC_NL_APP_T2 / `EMC_NL_DENOM);
   localparam logic [W-1:0] APP_T3 = W'(FULL_SCALE * `EMC_NL_APP_T3 / `EMC_NL_DENOM);
   localparam logic [W-1:0] PQ_T1 = W'(FULL_SCALE * `EMC_NL_PQ_T1 / `EMC_NL_DENOM);
   localparam logic [W-1:0] PQ_T2 = W'(FULL_SCALE * `EMC_NL_PQ_T2 / `EMC_NL_DENOM);
   localparam logic [W-1:0] PQ_T3 = W'(FULL_SCALE * `EMC_NL_PQ_T3 / `EMC_NL_DENOM);

   emc_pkg::emc_byte_t power_calc_mode_ctrl_two_reg;
   emc_pkg::emc_byte_t no_load_level_ctrl_reg;
   emc_pkg::emc_byte_t active_power_scale_reg;
   emc_pkg::emc_byte_t reactive_power_scale_reg;
   emc_pkg::emc_byte_t apparent_power_scale_reg;
   emc_pkg::emc_byte_t sfr_rdata_reg;
   logic apparent_noload_reg;
   logic reactive_noload_reg;
   logic active_noload_reg;

   // Register decode on the extended register port.
   wire sel_two = (sfr_addr == `EMC_ADDR_MODE_TWO);
   wire sel_nl = (sfr_addr == `EMC_ADDR_NO_LOAD);
   wire sel_act = (sfr_addr == `EMC_ADDR_ACT_SCALE);
   wire sel_rea = (sfr_addr == `EMC_ADDR_REA_SCALE);
   wire sel_app = (sfr_addr == `EMC_ADDR_APP_SCALE);
   wire wr_two = sfr_wr && sel_two;
   wire wr_nl = sfr_wr && sel_nl;
   wire wr_act = sfr_wr && sel_act;
   wire wr_rea = sfr_wr && sel_rea;
   wire wr_app = sfr_wr && sel_app;

   // The reserved bit is held at zero even if software breaks the write-zero convention.
   wire [7:0] two_wdata = sfr_wdata & `EMC_MODE_TWO_WMASK;

   wire [7:0] rd_mux = sel_two ? power_calc_mode_ctrl_two_reg :
                       sel_nl ? no_load_level_ctrl_reg :
                       sel_act ? active_power_scale_reg :
                       sel_rea ? reactive_power_scale_reg :
                       sel_app ? apparent_power_scale_reg : `EMC_UNMAPPED_VAL;

   // Register file; the extended port is the only way in.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         power_calc_mode_ctrl_two_reg <= `EMC_RESET_VAL;
         no_load_level_ctrl_reg <= `EMC_RESET_VAL;
         active_power_scale_reg <= `EMC_RESET_VAL;
         reactive_power_scale_reg <= `EMC_RESET_VAL;
         apparent_power_scale_reg <= `EMC_RESET_VAL;
      end
      else
      begin
         if (wr_two)
            power_calc_mode_ctrl_two_reg <= two_wdata;
         if (wr_nl)
            no_load_level_ctrl_reg <= sfr_wdata;
         if (wr_act)
            active_power_scale_reg <= sfr_wdata;
         if (wr_rea)
            reactive_power_scale_reg <= sfr_wdata;
         if (wr_app)
            apparent_power_scale_reg <= sfr_wdata;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         sfr_rdata_reg <= `EMC_RESET_VAL;
      else if (sfr_rd)
         sfr_rdata_reg <= rd_mux;
   end

   assign sfr_rdata = sfr_rdata_reg;
   assign active_power_scale = active_power_scale_reg;
   assign reactive_power_scale = reactive_power_scale_reg;
   assign apparent_power_scale = apparent_power_scale_reg;

   // Field views.
   wire act_dis = power_calc_mode_ctrl_two_reg[`EMC_B_ACT_DIS];
   wire rea_edge_sel = power_calc_mode_ctrl_two_reg[`EMC_B_REA_EDGE];
   wire act_edge_sel = power_calc_mode_ctrl_two_reg[`EMC_B_ACT_EDGE];
   wire rea_abs = power_calc_mode_ctrl_two_reg[`EMC_B_REA_ABS];
   wire rea_sdep = power_calc_mode_ctrl_two_reg[`EMC_B_REA_SDEP];
   wire act_pos = power_calc_mode_ctrl_two_reg[`EMC_B_ACT_POS];
   wire act_abs = power_calc_mode_ctrl_two_reg[`EMC_B_ACT_ABS];
   wire [1:0] app_lvl = no_load_level_ctrl_reg[`EMC_NL_APP_LSB +: 2];
   wire [1:0] rea_lvl = no_load_level_ctrl_reg[`EMC_NL_REA_LSB +: 2];
   wire [1:0] act_lvl = no_load_level_ctrl_reg[`EMC_NL_ACT_LSB +: 2];

   assign active_meas_en = calc_engine_enable && !act_dis;
   assign reactive_comp_en = !no_load_level_ctrl_reg[`EMC_B_COMP_DIS];
   assign rms_line_sync = no_load_level_ctrl_reg[`EMC_B_RMS_SYNC];

   // Absolute value wins over the sign option in both channels.
   wire emc_pkg::emc_accum_t rea_mode = rea_abs ? emc_pkg::EMC_ACC_ABS :
                                        rea_sdep ? emc_pkg::EMC_ACC_TAMPER :
                                        emc_pkg::EMC_ACC_SIGNED;
   wire emc_pkg::emc_accum_t act_mode = act_abs ? emc_pkg::EMC_ACC_ABS :
                                        act_pos ? emc_pkg::EMC_ACC_POS :
                                        emc_pkg::EMC_ACC_SIGNED;

   // No-load thresholds selected by level code.
   wire [W-1:0] app_thr = (app_lvl == `EMC_NL_LV1) ? APP_T1 :
                          (app_lvl == `EMC_NL_LV2) ? APP_T2 : APP_T3;
   wire [W-1:0] rea_thr = (rea_lvl == `EMC_NL_LV1) ? PQ_T1 :
                          (rea_lvl == `EMC_NL_LV2) ? PQ_T2 : PQ_T3;
   wire [W-1:0] act_thr = (act_lvl == `EMC_NL_LV1) ? PQ_T1 :
                          (act_lvl == `EMC_NL_LV2) ? PQ_T2 : PQ_T3;

   wire [W:0] act_ext = {active_power[W-1], active_power};
   wire [W:0] rea_ext = {reactive_power[W-1], reactive_power};
   wire [W:0] act_mag = act_ext[W] ? -act_ext : act_ext;
   wire [W:0] rea_mag = rea_ext[W] ? -rea_ext : rea_ext;

   wire app_below = (app_lvl != `EMC_NL_OFF) && (apparent_power < app_thr);
   wire rea_below = (rea_lvl != `EMC_NL_OFF) && (rea_mag < {1'b0, rea_thr});
   wire act_below = (act_lvl != `EMC_NL_OFF) && (act_mag < {1'b0, act_thr});

   wire sample_take = sample_valid && calc_engine_enable;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         apparent_noload_reg <= 1'b0;
         reactive_noload_reg <= 1'b0;
         active_noload_reg <= 1'b0;
      end
      else if (sample_take)
      begin
         apparent_noload_reg <= app_below;
         reactive_noload_reg <= rea_below;
         active_noload_reg <= act_below && !act_dis;
      end
   end

   assign apparent_noload = apparent_noload_reg;
   assign reactive_noload = reactive_noload_reg;
   assign active_noload = active_noload_reg;

   // Accumulation contributions handed to the energy accumulators and pulse output.
   emc_accum_unit #(.W(W)) u_act_accum (
      .clk(clk),
      .reset(reset),
      .enable(active_meas_en),
      .valid(sample_valid),
      .mode(act_mode),
      .value(active_power),
      .ref_neg(active_power[W-1]),
      .below_noload(act_below),
      .delta(active_accum_delta),
      .delta_valid(active_accum_valid)
   );

   // The anti-tamper direction follows the sign of the active sample of the same instant.
   emc_accum_unit #(.W(W)) u_rea_accum (
      .clk(clk),
      .reset(reset),
      .enable(calc_engine_enable),
      .valid(sample_valid),
      .mode(rea_mode),
      .value(reactive_power),
      .ref_neg(active_power[W-1]),
      .below_noload(rea_below),
      .delta(reactive_accum_delta),
      .delta_valid(reactive_accum_valid)
   );

   // Sign-change event detection.
   emc_sign_if act_sign ();
   emc_sign_if rea_sign ();

   assign act_sign.valid = sample_valid;
   assign act_sign.neg = active_power[W-1];
   assign act_sign.edge_sel = act_edge_sel;
   assign rea_sign.valid = sample_valid;
   assign rea_sign.neg = reactive_power[W-1];
   assign rea_sign.edge_sel = rea_edge_sel;

   emc_sign_detect u_act_sign (
      .clk(clk),
      .reset(reset),
      .enable(active_meas_en),
      .sig(act_sign.det)
   );

   emc_sign_detect u_rea_sign (
      .clk(clk),
      .reset(reset),
      .enable(calc_engine_enable),
      .sig(rea_sign.det)
   );

   assign active_sign_change_irq = act_sign.irq;
   assign reactive_sign_change_irq = rea_sign.irq;

   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence wr_two_dis_s;
      sfr_wr && sel_two && sfr_wdata[`EMC_B_ACT_DIS];
   endsequence

   sequence tamper_neg_s;
      sample_take && rea_mode == emc_pkg::EMC_ACC_TAMPER && rea_lvl == `EMC_NL_OFF
         && active_power[W-1];
   endsequence

   sequence app_small_s;
      sample_take && app_lvl == `EMC_NL_LV1 && apparent_power < APP_T1;
   endsequence

   sequence tamper_pos_s;
      sample_take && rea_sdep && !rea_abs && rea_lvl == `EMC_NL_OFF
         && !active_power[W-1];
   endsequence

   sequence rea_small_s;
      sample_take && rea_lvl == `EMC_NL_LV2 && !reactive_power[W-1]
         && reactive_power < PQ_T2;
   endsequence

   sequence act_small_s;
      sample_take && !act_dis && act_lvl == `EMC_NL_LV1 && !active_power[W-1]
         && active_power < PQ_T1;
   endsequence

   meas_disable_a: assert property (wr_two_dis_s |=> !active_meas_en ##1 !active_accum_valid)
      else $error("active measurement not stopped");
   rea_edge_dir_a: assert property (reactive_sign_change_irq |->
      $past(sample_take && (rea_edge_sel ? !reactive_power[W-1] : reactive_power[W-1])))
      else $error("reactive sign event in wrong direction");
   act_edge_dir_a: assert property (active_sign_change_irq |->
      $past(sample_take && (act_edge_sel ? !active_power[W-1] : active_power[W-1])))
      else $error("active sign event in wrong direction");
   tamper_negate_a: assert property (tamper_neg_s |=>
      reactive_accum_valid && reactive_accum_delta == -$past(rea_ext))
      else $error("anti-tamper did not subtract");
   tamper_add_a: assert property (tamper_pos_s |=>
      reactive_accum_valid && reactive_accum_delta == $past(rea_ext))
      else $error("anti-tamper did not add");
   rea_abs_a: assert property (sample_take && rea_abs && rea_lvl == `EMC_NL_OFF |=>
      reactive_accum_valid && !reactive_accum_delta[W])
      else $error("absolute reactive accumulated a negative value");
   pos_only_a: assert property (sample_take && !act_dis && act_mode == emc_pkg::EMC_ACC_POS
      |=> active_accum_valid && !active_accum_delta[W])
      else $error("positive-only accumulated a negative value");
   act_abs_a: assert property (sample_take && !act_dis && act_abs && act_lvl == `EMC_NL_OFF
      |=> active_accum_valid && !active_accum_delta[W])
      else $error("absolute active accumulated a negative value");
   comp_ctrl_a: assert property (sfr_wr && sel_nl |=>
      reactive_comp_en == !$past(sfr_wdata[`EMC_B_COMP_DIS]))
      else $error("compensation control not taken");
   rms_sync_a: assert property (sfr_wr && sel_nl |=>
      rms_line_sync == $past(sfr_wdata[`EMC_B_RMS_SYNC]))
      else $error("line synchronisation control not taken");
   app_noload_a: assert property (app_small_s |=> apparent_noload)
      else $error("apparent no-load not detected");
   app_off_a: assert property (sample_take && app_lvl == `EMC_NL_OFF |=> !apparent_noload)
      else $error("apparent no-load flagged while detection is off");
   rea_noload_a: assert property (rea_small_s |=>
      reactive_noload && reactive_accum_delta == '0)
      else $error("reactive no-load not detected");
   act_noload_a: assert property (act_small_s |=>
      active_noload && active_accum_delta == '0)
      else $error("active no-load not detected");
   scale_store_a: assert property (sfr_wr && sel_act |=>
      active_power_scale == $past(sfr_wdata) ##1 1'b1)
      else $error("active scaling value not stored");
   rea_scale_a: assert property (sfr_wr && sel_rea |=>
      reactive_power_scale == $past(sfr_wdata))
      else $error("reactive scaling value not stored");
   app_scale_a: assert property (sfr_wr && sel_app |=>
      apparent_power_scale == $past(sfr_wdata))
      else $error("apparent scaling value not stored");
   reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) reset |->
      power_calc_mode_ctrl_two_reg == `EMC_RESET_VAL && no_load_level_ctrl_reg == `EMC_RESET_VAL
      && active_power_scale_reg == `EMC_RESET_VAL && reactive_power_scale_reg == `EMC_RESET_VAL
      && apparent_power_scale_reg == `EMC_RESET_VAL)
      else $error("register not cleared by reset");
   engine_off_a: assert property (!calc_engine_enable |=>
      !reactive_accum_valid && !reactive_sign_change_irq)
      else $error("engine active while disabled");
   irq_single_a: assert property (reactive_sign_change_irq |=> !reactive_sign_change_irq)
      else $error("sign event lasted more than one cycle");
   act_irq_single_a: assert property (active_sign_change_irq |=> !active_sign_change_irq)
      else $error("active sign event lasted more than one cycle");
endmodule

// *** hw/emc_defines.svh ***
`ifndef EMC_DEFINES_SVH
`define EMC_DEFINES_SVH

// Extended register space: width of the address and the register locations.
`define EMC_SFR_AW 10
`define EMC_ADDR_MODE_TWO 10'h181
`define EMC_ADDR_NO_LOAD 10'h182
`define EMC_ADDR_ACT_SCALE 10'h183
`define EMC_ADDR_REA_SCALE 10'h184
`define EMC_ADDR_APP_SCALE 10'h185

`define EMC_RESET_VAL 8'h00
`define EMC_UNMAPPED_VAL 8'h00

// Field positions in the second mode control register.
`define EMC_B_ACT_DIS 7
`define EMC_B_RSVD 6
`define EMC_B_REA_EDGE 5
`define EMC_B_ACT_EDGE 4
`define EMC_B_REA_ABS 3
`define EMC_B_REA_SDEP 2
`define EMC_B_ACT_POS 1
`define EMC_B_ACT_ABS 0
`define EMC_MODE_TWO_WMASK 8'hbf

// Field positions in the no-load level control register.
`define EMC_B_COMP_DIS 7
`define EMC_B_RMS_SYNC 6
`define EMC_NL_APP_LSB 4
`define EMC_NL_REA_LSB 2
`define EMC_NL_ACT_LSB 0

// No-load level codes.
`define EMC_NL_OFF 2'h0
`define EMC_NL_LV1 2'h1
`define EMC_NL_LV2 2'h2

// Thresholds in millionths of full scale (0.03%, 0.015%, 0.0075%, 0.0037%).
`define EMC_NL_DENOM 1000000
`define EMC_NL_APP_T1 300
`define EMC_NL_APP_T2 150
`define EMC_NL_APP_T3 75
`define EMC_NL_PQ_T1 150
`define EMC_NL_PQ_T2 75
`define EMC_NL_PQ_T3 37

`endif

// *** hw/emc_pkg.sv ***
package emc_pkg;

   typedef enum logic [1:0] {
      EMC_ACC_SIGNED,
      EMC_ACC_ABS,
      EMC_ACC_TAMPER,
      EMC_ACC_POS
   } emc_accum_t;

   typedef logic [7:0] emc_byte_t;

endpackage

// *** hw/emc_sign_detect.sv ***
module emc_sign_detect (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   emc_sign_if.det sig
);
   logic seen_reg;
   logic prev_neg_reg;
   logic irq_reg;

   // No event is raised on the first sample after enabling: there is no previous sign yet.
   wire fall_edge = seen_reg && !prev_neg_reg && sig.neg;
   wire rise_edge = seen_reg && prev_neg_reg && !sig.neg;
   wire hit = sig.valid && enable && (sig.edge_sel ? rise_edge : fall_edge);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         seen_reg <= 1'b0;
         prev_neg_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= hit;
         if (!enable)
            seen_reg <= 1'b0;
         else if (sig.valid)
         begin
            seen_reg <= 1'b1;
            prev_neg_reg <= sig.neg;
         end
      end
   end

   assign sig.irq = irq_reg;
endmodule

// *** hw/emc_sign_if.sv ***
interface emc_sign_if;
   logic valid;
   logic neg;
   logic edge_sel;
   logic irq;

   modport src (output valid, output neg, output edge_sel, input irq);
   modport det (input valid, input neg, input edge_sel, output irq);
endinterface

// *** testbench/energy_meter_control_regs_tb.sv ***
`include "emc_defines.svh"

module energy_meter_control_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int W = 24;
   localparam longint FS = 64'h800000;

   logic clk = 1'b0;
   logic reset = 1'b0;
   logic [`EMC_SFR_AW-1:0] sfr_addr = '0;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic calc_engine_enable = 1'b0;
   logic sample_valid = 1'b0;
   logic signed [W-1:0] active_power = '0;
   logic signed [W-1:0] reactive_power = '0;
   logic [W-1:0] apparent_power = '0;
   logic active_meas_en, reactive_comp_en, rms_line_sync;
   logic [7:0] active_power_scale, reactive_power_scale, apparent_power_scale;
   logic signed [W:0] active_accum_delta, reactive_accum_delta;
   logic active_accum_valid, reactive_accum_valid;
   logic apparent_noload, reactive_noload, active_noload;
   logic active_sign_change_irq, reactive_sign_change_irq;

   int fail_count = 0;
   int checks_done = 0;
   int seed = 32'hdc25;
   logic [7:0] mode_reg = 8'h00;
   logic [7:0] nl_reg = 8'h00;
   logic hist_a = 1'b0;
   logic hist_r = 1'b0;
   logic prev_na = 1'b0;
   logic prev_nr = 1'b0;
   // Threshold tables in millionths of full scale, indexed by level code.
   int pq_t[4] = '{0, 150, 75, 37};
   int app_t[4] = '{0, 300, 150, 75};
   logic [7:0] v_tab[4] = '{8'h80, 8'h40, 8'hc0, 8'h15};

   emc_ctrl_regs #(.W(W)) i_emc_ctrl_regs (
      .clk(clk),
      .reset(reset),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .calc_engine_enable(calc_engine_enable),
      .sample_valid(sample_valid),
      .active_power(active_power),
      .reactive_power(reactive_power),
      .apparent_power(apparent_power),
      .active_meas_en(active_meas_en),
      .reactive_comp_en(reactive_comp_en),
      .rms_line_sync(rms_line_sync),
      .active_power_scale(active_power_scale),
      .reactive_power_scale(reactive_power_scale),
      .apparent_power_scale(apparent_power_scale),
      .active_accum_delta(active_accum_delta),
      .active_accum_valid(active_accum_valid),
      .reactive_accum_delta(reactive_accum_delta),
      .reactive_accum_valid(reactive_accum_valid),
      .apparent_noload(apparent_noload),
      .reactive_noload(reactive_noload),
      .active_noload(active_noload),
      .active_sign_change_irq(active_sign_change_irq),
      .reactive_sign_change_irq(reactive_sign_change_irq)
   );

   always #12.5 clk = ~clk;

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Every access is followed by an idle cycle so a strobe is never lowered and raised at once.
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk);
      #2;
      sfr_wr = 1'b0;
      if (a == `EMC_ADDR_MODE_TWO)
         mode_reg = d & `EMC_MODE_TWO_WMASK;
      if (a == `EMC_ADDR_NO_LOAD)
         nl_reg = d;
      @(posedge clk);
      #2;
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk);
      #2;
      sfr_rd = 1'b0;
      chk(sfr_rdata, exp);
      @(posedge clk);
      #2;
   endtask

   function automatic logic signed [W:0] exp_act(input logic signed [W-1:0] v);
      logic signed [W:0] x;
      x = v;
      if (mode_reg[0])
         return (x < 0) ? -x : x;
      if (mode_reg[1])
         return (x < 0) ? '0 : x;
      return x;
   endfunction

   function automatic logic signed [W:0] exp_rea(input logic signed [W-1:0] v, input logic an);
      logic signed [W:0] x;
      x = v;
      if (mode_reg[3])
         return (x < 0) ? -x : x;
      if (mode_reg[2])
         return an ? -x : x;
      return x;
   endfunction

   function automatic int thr(input int t);
      return int'(FS * t / 1000000);
   endfunction

   task automatic smp(input logic [W-1:0] a, input logic [W-1:0] r, input logic [W-1:0] s);
      logic na, nr, en_a, xa, xr;
      na = a[W-1];
      nr = r[W-1];
      en_a = calc_engine_enable & ~mode_reg[7];
      xa = en_a & hist_a & (mode_reg[4] ? (prev_na & ~na) : (~prev_na & na));
      xr = calc_engine_enable & hist_r & (mode_reg[5] ? (prev_nr & ~nr) : (~prev_nr & nr));
      active_power = a;
      reactive_power = r;
      apparent_power = s;
      sample_valid = 1'b1;
      @(posedge clk);
      #2;
      sample_valid = 1'b0;
      chk(active_accum_valid, en_a);
      chk(reactive_accum_valid, calc_engine_enable);
      chk(active_sign_change_irq, xa);
      chk(reactive_sign_change_irq, xr);
      if (en_a && nl_reg[1:0] == 2'h0)
         chk(active_accum_delta, exp_act(a));
      if (calc_engine_enable && nl_reg[3:2] == 2'h0)
         chk(reactive_accum_delta, exp_rea(r, na));
      hist_a = en_a;
      prev_na = na;
      hist_r = calc_engine_enable;
      prev_nr = nr;
      @(posedge clk);
      #2;
      chk({active_sign_change_irq, reactive_sign_change_irq}, 0);
   endtask

   initial
   begin
      #(25 * 20000);
      fail_count++;
      conclude();
   end

   initial
   begin
      logic [9:0] a;
      logic [7:0] v;
      logic [W-1:0] pa, pr;
      // Reset rises after time zero so that the asynchronous clear really sees an edge.
      #1;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      reset = 1'b0;
      for (int i = 0; i < 5; i++)
         rd(`EMC_ADDR_MODE_TWO + 10'(i), 8'h00);
      chk(reactive_comp_en, 1);
      chk(rms_line_sync, 0);
      for (int i = 0; i < 12; i++)
      begin
         a = `EMC_ADDR_ACT_SCALE + 10'(i % 3);
         v = (i < 3) ? 8'hff : (i < 6) ? 8'h00 : 8'($random(seed));
         wr(a, v);
         rd(a, v);
         chk(i % 3 == 0 ? active_power_scale : i % 3 == 1 ? reactive_power_scale
             : apparent_power_scale, v);
      end
      wr(10'h186, 8'hff);
      rd(10'h186, 8'h00);
      rd(10'h180, 8'h00);
      wr(`EMC_ADDR_MODE_TWO, 8'hff);
      rd(`EMC_ADDR_MODE_TWO, 8'hbf);
      for (int i = 0; i < 4; i++)
      begin
         calc_engine_enable = i[1];
         wr(`EMC_ADDR_MODE_TWO, {i[0], 7'h00});
         chk(active_meas_en, i[1] & ~i[0]);
      end
      foreach (v_tab[k])
      begin
         wr(`EMC_ADDR_NO_LOAD, v_tab[k]);
         chk(reactive_comp_en, !v_tab[k][7]);
         chk(rms_line_sync, v_tab[k][6]);
         rd(`EMC_ADDR_NO_LOAD, v_tab[k]);
      end
      wr(`EMC_ADDR_NO_LOAD, 8'h00);
      calc_engine_enable = 1'b1;
      for (int m = 0; m < 192; m++)
      begin
         wr(`EMC_ADDR_MODE_TWO, 8'(m < 64 ? m : (m < 128 ? 8'h80 | m : m)));
         for (int j = 0; j < 4; j++)
         begin
            pa = (j == 0) ? '0 : (j == 1) ? 24'h800000 : 24'($random(seed));
            pr = (j == 1) ? 24'h800000 : 24'($random(seed));
            if (m >= 160)
               calc_engine_enable = j[0];
            smp(pa, pr, 24'($random(seed)));
         end
      end
      calc_engine_enable = 1'b1;
      wr(`EMC_ADDR_MODE_TWO, 8'h00);
      for (int lv = 1; lv < 4; lv++)
      begin
         wr(`EMC_ADDR_NO_LOAD, {2'h0, 2'(lv), 2'(lv), 2'(lv)});
         smp(24'(thr(pq_t[lv]) / 2), 24'(thr(pq_t[lv]) / 2), 24'(thr(app_t[lv]) / 2));
         chk({apparent_noload, reactive_noload, active_noload}, 7);
         smp(24'(thr(pq_t[lv]) * 2), -24'(thr(pq_t[lv]) * 2), 24'(thr(app_t[lv]) * 2));
         chk({apparent_noload, reactive_noload, active_noload}, 0);
      end
      wr(`EMC_ADDR_NO_LOAD, 8'h00);
      smp(24'h1, 24'h1, 24'h1);
      chk({apparent_noload, reactive_noload, active_noload}, 0);
      wr(`EMC_ADDR_APP_SCALE, 8'h5a);
      reset = 1'b1;
      @(posedge clk);
      #2;
      reset = 1'b0;
      mode_reg = 8'h00;
      hist_a = 1'b0;
      hist_r = 1'b0;
      for (int i = 0; i < 5; i++)
         rd(`EMC_ADDR_MODE_TWO + 10'(i), 8'h00);
      conclude();
   end
endmodule
